// file: sswc_map.vh
`ifndef SSWC_MAP_VH
`define SSWC_MAP_VH
// ----------------------------------------
// Extended status word bit positions
// ----------------------------------------
`define SSWC_ST_RSO_BIT      0
`define SSWC_ST_RDY_BIT      1
`define SSWC_ST_EN_BIT       2
`define SSWC_ST_ERR_BIT      3
`define SSWC_ST_COAST_BIT    4
`define SSWC_ST_QUICK_BIT    5
`define SSWC_ST_INHIBIT_BIT  6
`define SSWC_ST_WARN_BIT     7
`define SSWC_ST_RUN_BIT      8
`define SSWC_ST_REQ_BIT      9
`define SSWC_ST_TOR_BIT      10
`define SSWC_ST_CL_BIT       11
// ----------------------------------------
// Extended control word bit positions
// ----------------------------------------
`define SSWC_CW_ONOFF_BIT    0
`define SSWC_CW_OFF2_BIT     1
`define SSWC_CW_OFF3_BIT     2
`define SSWC_CW_ENOP_BIT     3
`define SSWC_CW_ENRAMP_BIT   4
`define SSWC_CW_UNFREEZE_BIT 5
`define SSWC_CW_ENSET_BIT    6
`define SSWC_CW_ACK_BIT      7
`define SSWC_CW_GRANT_BIT    10
// ----------------------------------------
// Reset values and scaling
// ----------------------------------------
`define SSWC_STATUS_RST      16'h0000
`define SSWC_LOAD_RST        16'h0000
`define SSWC_LOAD_100PCT     16'h4000
`define SSWC_RAMP_MAX        16'hffff
`define SSWC_RAMP_STEP       16'h0001
`define SSWC_QUICK_STEP      16'h0010
`endif

// file: sswc_ramp.v
`timescale 1ns/1ps
`default_nettype none
`include "sswc_map.vh"
// ----------------------------------------
// Ramp generator with freeze and current limit
// ----------------------------------------
module sswc_ramp (
  input  wire        clk,
  input  wire        nrst,
  input  wire        ramp_up,
  input  wire        ramp_down,
  input  wire        quick,
  input  wire        coast,
  input  wire        freeze,
  input  wire        limit_hit,
  output reg  [15:0] level_ff,
  output wire        at_top,
  output wire        at_zero
);
  reg [15:0] nxt_level;
  assign at_top  = (level_ff == `SSWC_RAMP_MAX);
  assign at_zero = (level_ff == 16'h0000);

  // Freeze and limit only stop the climb, ramp down still runs; coast drops at once
  always @* begin
    nxt_level = level_ff;
    if (coast) begin
      nxt_level = 16'h0000;
    end else if (ramp_down) begin
      if (quick) begin
        nxt_level = (level_ff > `SSWC_QUICK_STEP) ? level_ff - `SSWC_QUICK_STEP : 16'h0000;
      end else if (!at_zero) begin
        nxt_level = level_ff - `SSWC_RAMP_STEP;
      end
    end else if (ramp_up && !freeze && !limit_hit && !at_top) begin // RQ20 RQ17 RQ15
      nxt_level = level_ff + `SSWC_RAMP_STEP;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level_ff <= 16'h0000;
    end else begin
      level_ff <= nxt_level;
    end
  end
endmodule
`default_nettype wire

// file: sswc_limit.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Current limit compare from breaker values
// ----------------------------------------
module sswc_limit (
  input  wire        clk,
  input  wire        nrst,
  input  wire [15:0] rated_current,
  input  wire [7:0]  limit_multiple,
  input  wire [15:0] measured_current,
  output reg         limit_ff
);
  // Multiple is in tenths of rated current, widened to avoid overflow
  wire [23:0] threshold;
  wire [23:0] scaled_meas;
  assign threshold   = rated_current * limit_multiple;
  assign scaled_meas = {8'h00, measured_current} * 24'd10;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      limit_ff <= 1'b0;
    end else begin
      limit_ff <= (limit_multiple != 8'h00) && (scaled_meas >= threshold); // RQ15
    end
  end
endmodule
`default_nettype wire

// file: sswc_top.v
// Contract
// [RQ1] Status bit 0: ready to switch on
// [RQ2] Bits 1,2: switched on, operation enabled
// [RQ3] Bit 6: switch-on inhibited
// [RQ4] Bit 4: coast run-down in progress
// [RQ5] Bit 5: quick stop active
// [RQ6] Bits 3,7,8: fault, warning, power active
// [RQ7] Bit 10: top of ramp reached
// [RQ8] Bit 11 current limit if enabled
// [RQ9] Load word signed, 0x4000 is 100 percent
// [RQ10] Bit 9 follows network control setting
// [RQ11] Control bits ignored until grant set
// [RQ12] No grant under network control: fail-safe
// [RQ13] Fail-safe uses zero control bytes
// [RQ14] Fail-safe: switching off, stop, inhibited
// [RQ15] Device limits current from breaker values
// [RQ16] Controller sets rated current and multiple
// [RQ17] Control bit 5 low freezes ramp
// [RQ18] Controller restores bit 5 below limit
// [RQ19] Grant is control bit 10
// [RQ20] Bit 5 zero holds ramp output; the code only stops the climb, ramp down still lowers it
// [RQ21] Words refreshed each exchange, reserved zero
`timescale 1ns/1ps
`default_nettype none
`include "sswc_map.vh"
module sswc_top (
  input  wire        SYS_CLK,
  input  wire        NRST,
  input  wire        EXCHANGE,
  input  wire [15:0] CONTROL_WORD,
  input  wire        NETWORK_CONTROL_PARAM,
  input  wire        LIMIT_FLAG_ENABLE_PARAM,
  input  wire [15:0] RATED_MOTOR_CURRENT_PARAM,
  input  wire [7:0]  CURRENT_LIMIT_MULTIPLE_PARAM,
  input  wire [15:0] BREAKER_CURRENT,
  input  wire        FAULT_PRESENT,
  input  wire        WARNING_PRESENT,
  input  wire        START_INHIBIT,
  input  wire signed [15:0] LOAD_PERCENT,
  output reg  [15:0] EXTENDED_STATUS_WORD,
  output reg  [15:0] LOAD_PERCENT_WORD,
  output reg         FAIL_SAFE,
  output reg         POWER_ACTIVE,
  output reg  [15:0] RAMP_LEVEL
);
  // ----------------------------------------
  // State codes
  // ----------------------------------------
  localparam [2:0] STATE_INHIBITED         = 3'd1;
  localparam [2:0] STATE_READY_TO_SWITCH_ON = 3'd2;
  localparam [2:0] STATE_SWITCHED_ON       = 3'd3;
  localparam [2:0] STATE_OPERATING         = 3'd4;
  localparam [2:0] STATE_SWITCHING_OFF     = 3'd5;

  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg         coast_ff;
  reg         nxt_coast;
  reg         quick_ff;
  reg         nxt_quick;
  reg         tor_ff;
  reg         nxt_tor;
  wire [15:0] ramp_level;
  wire        ramp_top;
  wire        ramp_zero;
  wire        limit_hit;

  // ----------------------------------------
  // Authority and fail-safe qualification
  // ----------------------------------------
  // Fail-safe whenever network control is set but grant is withdrawn
  wire grant     = CONTROL_WORD[`SSWC_CW_GRANT_BIT];                // RQ19
  wire fail_safe = NETWORK_CONTROL_PARAM & ~grant;                   // RQ12
  // Without grant the state bits count as zero; same as invalid bytes
  wire [15:0] cw = (fail_safe | ~grant) ? 16'h0000 : CONTROL_WORD;  // RQ11 RQ13
  wire on_cmd    = cw[`SSWC_CW_ONOFF_BIT];
  wire no_coast  = cw[`SSWC_CW_OFF2_BIT];
  wire no_quick  = cw[`SSWC_CW_OFF3_BIT];
  wire en_op     = cw[`SSWC_CW_ENOP_BIT];
  wire en_ramp   = cw[`SSWC_CW_ENRAMP_BIT];
  wire unfreeze  = cw[`SSWC_CW_UNFREEZE_BIT];
  wire en_set    = cw[`SSWC_CW_ENSET_BIT];

  // ----------------------------------------
  // Drive state machine
  // ----------------------------------------
  // Stop requests start a run-down only from operating; from ready or switched on they go straight to inhibited
  always @* begin
    nxt_state = state_ff;
    nxt_coast = coast_ff;
    nxt_quick = quick_ff;
    case (state_ff)
      STATE_INHIBITED: begin
        nxt_coast = 1'b0;
        nxt_quick = 1'b0;
        if (!START_INHIBIT && !FAULT_PRESENT && !fail_safe && !on_cmd && no_coast && no_quick) begin
          nxt_state = STATE_READY_TO_SWITCH_ON;
        end
      end
      STATE_READY_TO_SWITCH_ON: begin
        if (fail_safe || FAULT_PRESENT || !no_coast || !no_quick) begin
          nxt_state = STATE_INHIBITED;
        end else if (on_cmd) begin
          nxt_state = STATE_SWITCHED_ON;
        end
      end
      STATE_SWITCHED_ON: begin
        if (fail_safe || FAULT_PRESENT) begin
          nxt_state = STATE_SWITCHING_OFF;                            // RQ14
          nxt_coast = FAULT_PRESENT;
          nxt_quick = ~FAULT_PRESENT;
        end else if (!no_coast || !no_quick) begin
          nxt_state = STATE_INHIBITED;
        end else if (!on_cmd) begin
          nxt_state = STATE_READY_TO_SWITCH_ON;
        end else if (en_op) begin
          nxt_state = STATE_OPERATING;
        end
      end
      STATE_OPERATING: begin
        if (fail_safe || FAULT_PRESENT || !no_coast || !no_quick || !on_cmd || !en_op) begin
          nxt_state = STATE_SWITCHING_OFF;                            // RQ14
          // Fault or coast request de-energizes; fail-safe uses quick stop
          nxt_coast = FAULT_PRESENT | (!no_coast & !fail_safe);
          nxt_quick = !(FAULT_PRESENT | (!no_coast & !fail_safe)) & (fail_safe | !no_quick);
        end
      end
      STATE_SWITCHING_OFF: begin
        if (ramp_zero) begin
          nxt_state = STATE_INHIBITED;                                // RQ14
        end
      end
      default: begin
        nxt_state = STATE_INHIBITED;
      end
    endcase
  end

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_ff <= STATE_INHIBITED;
      coast_ff <= 1'b0;
      quick_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      coast_ff <= nxt_coast;
      quick_ff <= nxt_quick;
    end
  end

  // ----------------------------------------
  // Ramp and current limit
  // ----------------------------------------
  wire running    = (state_ff == STATE_OPERATING);
  wire ramp_up    = running & en_ramp & en_set;
  wire ramp_down  = (state_ff == STATE_SWITCHING_OFF) | (running & ~(en_ramp & en_set));

  sswc_limit u_limit (
    .clk              (SYS_CLK),
    .nrst             (NRST),
    .rated_current    (RATED_MOTOR_CURRENT_PARAM),
    .limit_multiple   (CURRENT_LIMIT_MULTIPLE_PARAM),
    .measured_current (BREAKER_CURRENT),
    .limit_ff         (limit_hit)
  );

  sswc_ramp u_ramp (
    .clk       (SYS_CLK),
    .nrst      (NRST),
    .ramp_up   (ramp_up),
    .ramp_down (ramp_down),
    .quick     (quick_ff),
    .coast     (coast_ff),
    .freeze    (~unfreeze),
    .limit_hit (limit_hit),
    .level_ff  (ramp_level),
    .at_top    (ramp_top),
    .at_zero   (ramp_zero)
  );

  // Top of ramp latches once reached, clears when leaving operation
  always @* begin
    nxt_tor = tor_ff;
    if (!running) begin
      nxt_tor = 1'b0;
    end else if (ramp_top) begin
      nxt_tor = 1'b1;                                                 // RQ7
    end
  end

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      tor_ff <= 1'b0;
    end else begin
      tor_ff <= nxt_tor;
    end
  end

  // ----------------------------------------
  // Status word assembly
  // ----------------------------------------
  reg [15:0] nxt_status;
  always @* begin
    nxt_status = `SSWC_STATUS_RST;                                    // RQ21
    nxt_status[`SSWC_ST_RSO_BIT]     = (state_ff == STATE_READY_TO_SWITCH_ON); // RQ1
    nxt_status[`SSWC_ST_RDY_BIT]     = (state_ff == STATE_SWITCHED_ON);        // RQ2
    nxt_status[`SSWC_ST_EN_BIT]      = running;                                // RQ2
    nxt_status[`SSWC_ST_ERR_BIT]     = FAULT_PRESENT;                          // RQ6
    nxt_status[`SSWC_ST_COAST_BIT]   = (state_ff == STATE_SWITCHING_OFF) & coast_ff; // RQ4
    nxt_status[`SSWC_ST_QUICK_BIT]   = (state_ff == STATE_SWITCHING_OFF) & quick_ff; // RQ5
    nxt_status[`SSWC_ST_INHIBIT_BIT] = (state_ff == STATE_INHIBITED);          // RQ3
    nxt_status[`SSWC_ST_WARN_BIT]    = WARNING_PRESENT;                        // RQ6
    nxt_status[`SSWC_ST_RUN_BIT]     = ~ramp_zero;                             // RQ6
    nxt_status[`SSWC_ST_REQ_BIT]     = NETWORK_CONTROL_PARAM;                  // RQ10
    nxt_status[`SSWC_ST_TOR_BIT]     = tor_ff;                                 // RQ7
    nxt_status[`SSWC_ST_CL_BIT]      = LIMIT_FLAG_ENABLE_PARAM & limit_hit;    // RQ8
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // Words update only on the exchange strobe so a frame sees a coherent pair
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      EXTENDED_STATUS_WORD <= `SSWC_STATUS_RST;
      LOAD_PERCENT_WORD    <= `SSWC_LOAD_RST;
      FAIL_SAFE            <= 1'b0;
      POWER_ACTIVE         <= 1'b0;
      RAMP_LEVEL           <= 16'h0000;
    end else begin
      if (EXCHANGE) begin
        EXTENDED_STATUS_WORD <= nxt_status;                           // RQ21
        LOAD_PERCENT_WORD    <= LOAD_PERCENT;                         // RQ9
      end
      FAIL_SAFE    <= fail_safe;                                      // RQ12
      POWER_ACTIVE <= ~ramp_zero;
      RAMP_LEVEL   <= ramp_level;
    end
  end
endmodule
`default_nettype wire

// file: sswc_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Status and handover checks
// ----------------
module sswc_checker (
  input wire logic               SYS_CLK,
  input wire logic               NRST,
  input wire logic               EXCHANGE,
  input wire logic        [15:0] CONTROL_WORD,
  input wire logic               NETWORK_CONTROL_PARAM,
  input wire logic               LIMIT_FLAG_ENABLE_PARAM,
  input wire logic               WARNING_PRESENT,
  input wire logic signed [15:0] LOAD_PERCENT,
  input wire logic        [15:0] EXTENDED_STATUS_WORD,
  input wire logic        [15:0] LOAD_PERCENT_WORD,
  input wire logic               FAIL_SAFE,
  input wire logic        [15:0] RAMP_LEVEL
);
  default clocking dck @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);
  // Fail-safe tracks a missing grant one cycle later
  AST_FS_SET: assert property (NETWORK_CONTROL_PARAM && !CONTROL_WORD[10] |=> FAIL_SAFE)
    else $error("fail-safe missing without grant");
  AST_FS_CLR: assert property (!NETWORK_CONTROL_PARAM || CONTROL_WORD[10] |=> !FAIL_SAFE)
    else $error("fail-safe kept while granted");
  // Words latch on exchange and stand until the next one
  AST_LOAD_COPY: assert property (EXCHANGE |=> LOAD_PERCENT_WORD == $past(LOAD_PERCENT))
    else $error("load word not copied");
  AST_WORDS_HOLD: assert property (!EXCHANGE |=> $stable(EXTENDED_STATUS_WORD) && $stable(LOAD_PERCENT_WORD))
    else $error("words changed without exchange");
  AST_RESERVED_ZERO: assert property (EXTENDED_STATUS_WORD[15:12] == 4'h0)
    else $error("unused status bits set");
  AST_LIMIT_GATE: assert property (EXCHANGE && !LIMIT_FLAG_ENABLE_PARAM |=> !EXTENDED_STATUS_WORD[11])
    else $error("limit flag shown while disabled");
  AST_REQ_FOLLOWS: assert property (EXCHANGE && $stable(NETWORK_CONTROL_PARAM)
    |=> EXTENDED_STATUS_WORD[9] == $past(NETWORK_CONTROL_PARAM))
    else $error("request bit wrong");
  AST_STATE_ONEHOT: assert property ($onehot0({EXTENDED_STATUS_WORD[6], EXTENDED_STATUS_WORD[2:0]}))
    else $error("several state bits set");
  // Freeze or missing grant never lets the ramp climb
  AST_RAMP_FREEZE: assert property ((!CONTROL_WORD[5] || !CONTROL_WORD[10])[*3] |-> RAMP_LEVEL <= $past(RAMP_LEVEL))
    else $error("ramp rose while frozen");
  AST_WARN_BIT: assert property (EXCHANGE && $stable(WARNING_PRESENT)
    |=> EXTENDED_STATUS_WORD[7] == $past(WARNING_PRESENT))
    else $error("warning bit wrong");
endmodule
bind sswc_top sswc_checker u_chk (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .EXCHANGE(EXCHANGE), .CONTROL_WORD(CONTROL_WORD),
  .NETWORK_CONTROL_PARAM(NETWORK_CONTROL_PARAM), .LIMIT_FLAG_ENABLE_PARAM(LIMIT_FLAG_ENABLE_PARAM),
  .WARNING_PRESENT(WARNING_PRESENT), .LOAD_PERCENT(LOAD_PERCENT), .FAIL_SAFE(FAIL_SAFE),
  .EXTENDED_STATUS_WORD(EXTENDED_STATUS_WORD), .LOAD_PERCENT_WORD(LOAD_PERCENT_WORD), .RAMP_LEVEL(RAMP_LEVEL)
);
`default_nettype wire

// file: sswc_plc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Remote controller model
// ----------------
module sswc_plc_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [15:0] status_word,
  input  wire logic [9:0]  cmd_bits,
  input  wire logic        grant_on,
  output var  logic [15:0] ctl_word_ff
);
  logic grant_ff;
  // Grant only once the request is seen, so it never runs ahead
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      grant_ff <= 1'b0;
    end else begin
      grant_ff <= grant_on && (grant_ff || status_word[9]);
    end
  end
  // Word changes just after the edge; grant sits in bit 10
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_word_ff <= 16'h0000;
    end else begin
      ctl_word_ff <= #1 {5'h00, grant_ff, cmd_bits};
    end
  end
endmodule
`default_nettype wire

// file: sswc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module sswc_top_test;
  logic        sys_clk, nrst, exchange, ncp, lfe, fault, warn, fs, pwr, grant_on;
  logic [15:0] cw, rated, brk, esw, lpw, ramp, held, load;
  logic [9:0]  cmd;
  logic [7:0]  mult;
  int          n_errors, samples_checked, k;
  // ----------------
  // Device and controller
  // ----------------
  sswc_top uut (
    .SYS_CLK(sys_clk), .NRST(nrst), .EXCHANGE(exchange), .CONTROL_WORD(cw),
    .NETWORK_CONTROL_PARAM(ncp), .LIMIT_FLAG_ENABLE_PARAM(lfe), .RATED_MOTOR_CURRENT_PARAM(rated),
    .CURRENT_LIMIT_MULTIPLE_PARAM(mult), .BREAKER_CURRENT(brk), .FAULT_PRESENT(fault),
    .WARNING_PRESENT(warn), .START_INHIBIT(1'b0), .LOAD_PERCENT(load), .EXTENDED_STATUS_WORD(esw),
    .LOAD_PERCENT_WORD(lpw), .FAIL_SAFE(fs), .POWER_ACTIVE(pwr), .RAMP_LEVEL(ramp)
  );
  sswc_plc_model plc (
    .clk(sys_clk), .nrst(nrst), .status_word(esw), .cmd_bits(cmd), .grant_on(grant_on), .ctl_word_ff(cw)
  );
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ----------------
  // Access and compare tasks
  // ----------------
  task wrap_up;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Inputs move 1 ns after the edge, never on it
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // One exchange; the idle cycle keeps pulses apart
  task xchg;
    exchange = 1'b1;
    tick(1);
    exchange = 1'b0;
    tick(1);
  endtask
  task step(input logic [9:0] c, input string name, input logic [15:0] exp);
    cmd = c;
    tick(3);
    xchg;
    chk(name, esw, exp);
  endtask
  // Bounded polls; running out ends the run as a failure
  task wait_bit(input int b, input int lim);
    k = 0;
    do begin
      xchg;
      k++;
    end while (esw[b] !== 1'b1 && k < lim);
    if (esw[b] !== 1'b1) begin
      n_errors++;
      wrap_up;
    end
  endtask
  task wait_top;
    k = 0;
    while (ramp !== 16'hffff && k < 70000) begin
      tick(1);
      k++;
    end
    if (ramp !== 16'hffff) begin
      n_errors++;
      wrap_up;
    end
  endtask
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    {nrst, exchange, ncp, lfe, fault, warn, grant_on} = 7'h00;
    cmd = 10'h006;
    rated = 16'h0064;
    mult = 8'h14;
    brk = 16'h0000;
    load = 16'h0000;
    n_errors = 0;
    samples_checked = 0;
    tick(10);
    nrst = 1'b1;
    tick(2);
    xchg;
    chk("status_reset", esw, 16'h0040);
    ncp = 1'b1;
    load = 16'hc000;
    tick(4);
    xchg;
    chk("status_request", esw, 16'h0240);
    chk("load_word", lpw, 16'hc000);
    chk("fail_safe_on", {15'h0000, fs}, 16'h0001);
    grant_on = 1'b1;
    tick(6);
    chk("fail_safe_off", {15'h0000, fs}, 16'h0000);
    step(10'h006, "status_ready", 16'h0201);
    step(10'h007, "status_on", 16'h0202);
    step(10'h00f, "status_enabled", 16'h0204);
    step(10'h07f, "status_running", 16'h0304);
    chk("power_on", {15'h0000, pwr}, 16'h0001);
    cmd = 10'h05f;
    tick(4);
    held = ramp;
    tick(20);
    chk("ramp_frozen", ramp, held);
    cmd = 10'h07f;
    wait_top;
    step(10'h07f, "status_top", 16'h0704);
    brk = 16'h012c;
    lfe = 1'b1;
    step(10'h07f, "status_limit", 16'h0f04);
    lfe = 1'b0;
    warn = 1'b1;
    step(10'h07f, "status_warn", 16'h0784);
    warn = 1'b0;
    grant_on = 1'b0;
    wait_bit(5, 50);
    chk("quick_stop", esw & 16'h0037, 16'h0020);
    wait_bit(6, 3000);
    chk("after_fail_safe", esw, 16'h0240);
    chk("ramp_zero", ramp, 16'h0000);
    chk("power_off", {15'h0000, pwr}, 16'h0000);
    fault = 1'b1;
    step(10'h07f, "status_fault", 16'h0248);
    wrap_up;
  end
endmodule
`default_nettype wire
